// ==== logic/casbd_cfg.svh ====
// constants for the word, multiply, shift and bit-carry execution datapath
// What this block does
// - word_add sums accumulator_pair with immediate, pair or memory; flags; immediate 3 bytes, 1 clock
// - word_subtract stores difference, borrow in carry; memory 1 clock, 4 from flash
// - word_compare subtracts and sets flags but keeps accumulator_pair unchanged
// - extra_segment prefix adds one byte and one clock: 2 internal, 5 flash
// - byte multiply A by X into accumulator_pair, flags unchanged
// - word unsigned multiply: high half to second_pair, low to accumulator_pair; 3 bytes
// - signed word multiply keeps same placement with two's-complement operands and product
// - word divide: quotient in accumulator_pair, remainder in third_pair, nine clocks
// - long divide of second:accumulator by pointer:third pairs, seventeen clocks
// - unsigned multiply-accumulate adds product into product_accumulator, sets aux carry and carry
// - fetch from internal RAM stretches time to twice the count plus three
// - word add/subtract one changes value by one, no flag; register form one byte
// - logical right shifts fill top with zero, last bit out to carry
// - left shifts move top bit into carry each step, fill bit 0 with zero
// - arithmetic right shifts move bit 0 to carry and replicate sign
// - byte rotates wrap end bit around and copy it into carry
// - rotates through carry use carry as extra bit, word form for left
// - bit and/or combine carry with selected bit, result to carry only
// - bit or with peripheral register bit: one clock, three bytes, carry only
`ifndef CASBD_CFG_SVH
`define CASBD_CFG_SVH
`define CASBD_A_AX 6'h00
`define CASBD_A_BC 6'h04
`define CASBD_A_DE 6'h08
`define CASBD_A_HL 6'h0c
`define CASBD_A_MACL 6'h10
`define CASBD_A_SIGNED_PRODUCT_ACCUMULATE 6'h14
`define CASBD_A_PSW 6'h18
`define CASBD_A_CTRL 6'h1c
`define CASBD_A_STAT 6'h20
`define CASBD_PSW_Z 6
`define CASBD_PSW_AC 4
`define CASBD_PSW_CY 0
`define CASBD_CTRL_RAMF 0
`define CASBD_PSW_RST 8'h06
`define CASBD_CLK_ONE 6'd1
`define CASBD_CLK_FLASH 6'd4
`define CASBD_CLK_ES 6'd1
`define CASBD_CLK_MUL16 6'd2
`define CASBD_CLK_MAC 6'd3
`define CASBD_CLK_DIVH 6'd9
`define CASBD_CLK_DIVW 6'd17
`define CASBD_CLK_RMW 6'd2
`define CASBD_CLK_PSWBIT 6'd4
`define CASBD_CLK_RAMF 6'd3
`define CASBD_BY_ONE 3'd1
`define CASBD_BY_TWO 3'd2
`define CASBD_BY_THREE 3'd3
`define CASBD_RESP_OK 2'b00
`define CASBD_RESP_ERR 2'b10
`endif

// ==== logic/casbd_pkg.sv ====
// types of the execution datapath
package casbd_pkg;
  typedef enum logic [4:0] {
    OP_WORD_ADD, OP_WORD_SUBTRACT, OP_WORD_COMPARE, OP_BYTE_UNSIGNED_MULTIPLY,
    OP_WORD_UNSIGNED_MULTIPLY, OP_WORD_SIGNED_MULTIPLY, OP_WORD_UNSIGNED_DIVIDE,
    OP_LONG_UNSIGNED_DIVIDE, OP_UNSIGNED_PRODUCT_ACCUMULATE, OP_SIGNED_PRODUCT_ACCUMULATE,
    OP_BYTE_ADD_ONE, OP_BYTE_SUBTRACT_ONE, OP_WORD_ADD_ONE, OP_WORD_SUBTRACT_ONE,
    OP_BYTE_LOGICAL_RIGHT, OP_WORD_LOGICAL_RIGHT, OP_BYTE_LEFT_MOVE, OP_WORD_LEFT_MOVE,
    OP_BYTE_ARITH_RIGHT, OP_WORD_ARITH_RIGHT, OP_BYTE_ROTATE_RIGHT, OP_BYTE_ROTATE_LEFT,
    OP_ROTATE_RIGHT_THROUGH_CARRY, OP_ROTATE_LEFT_THROUGH_CARRY,
    OP_WORD_ROTATE_LEFT_THROUGH_CARRY, OP_BIT_TO_CARRY, OP_CARRY_TO_BIT,
    OP_SINGLE_BIT_AND, OP_SINGLE_BIT_OR
  } casbd_op_t;
  // operand form: immediate, register, memory word/byte, peripheral, status word, accumulator
  typedef enum logic [2:0] {
    SRC_IMM, SRC_REG, SRC_MEM, SRC_SFR, SRC_PSW, SRC_ACC
  } casbd_src_t;
  typedef enum logic [1:0] {SHK_LEFT, SHK_LOG, SHK_ARITH} casbd_shk_t;
  typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_BUSY = 2'b10} casbd_st_t;
  typedef struct packed {
    casbd_op_t op;
    casbd_src_t src;
    logic es;
    logic flash;
    logic [2:0] rsel;
    logic [3:0] cnt;
    logic [2:0] bitn;
    logic [15:0] imm;
    logic [15:0] mem;
  } casbd_req_t;
  typedef struct packed {
    logic [2:0] bytes;
    logic [5:0] clocks;
    logic mem_we;
    logic [15:0] mem_wdata;
  } casbd_rsp_t;
  typedef struct packed {
    casbd_st_t st;
    logic [5:0] cnt;
    logic [3:0][15:0] rp;
    logic [31:0] mac;
    logic [7:0] program_status_word;
    logic [7:0] ctrl;
    casbd_rsp_t rsp;
    logic done;
    logic aw_got;
    logic w_got;
    logic [5:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } casbd_state_t;
endpackage

// ==== logic/casbd_datapath.sv ====
// execution datapath: word arithmetic, multiply/divide, shifts, rotates, carry bit ops
//
// Chosen here: the placing of the registers and register access over AXI4-Lite.
module casbd_datapath (
  input wire logic sys_clk, // cpu clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic op_valid, // decoder offers an operation
  output logic op_ready, // datapath idle, takes the operation
  input wire casbd_pkg::casbd_req_t op_req, // operation and operands
  output logic op_done, // one-cycle pulse when the operation's clocks are spent
  output casbd_pkg::casbd_rsp_t op_rsp, // byte count, clock count, memory write-back
  input wire logic [5:0] s_axi_awaddr, // axi4-lite write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write byte strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [5:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready // read data ready
);
  import casbd_pkg::*;
  `include "casbd_cfg.svh"

  casbd_state_t q, d;

  // {carry, aux carry, sum}; aux carry is the carry or borrow out of bit 3
  function automatic logic [17:0] add_sub(input logic [15:0] a, input logic [15:0] b,
                                          input logic sub);
    logic [16:0] s;
    logic [4:0] l;
    s = sub ? ({1'b0, a} - {1'b0, b}) : ({1'b0, a} + {1'b0, b});
    l = sub ? ({1'b0, a[3:0]} - {1'b0, b[3:0]}) : ({1'b0, a[3:0]} + {1'b0, b[3:0]});
    return {s[16], l[4], s[15:0]};
  endfunction

  // {carry, value}; a count of zero is a no-op, larger counts are clipped to width-1
  function automatic logic [16:0] shift_n(input logic [15:0] v, input logic c,
                                          input logic [3:0] n, input logic w,
                                          input casbd_shk_t k);
    logic [15:0] x;
    logic cy;
    logic [3:0] lim;
    x = w ? v : {8'h00, v[7:0]};
    cy = c;
    lim = w ? 4'd15 : 4'd7;
    if (n < lim) lim = n;
    for (int i = 0; i < 15; i++) begin
      if (4'(i) < lim) begin
        unique case (k)
          SHK_LEFT: begin
            cy = w ? x[15] : x[7];
            x = {x[14:0], 1'b0};
          end
          SHK_LOG: begin
            cy = x[0];
            x = {1'b0, x[15:1]};
          end
          default: begin
            cy = x[0];
            x = w ? {x[15], x[15:1]} : {8'h00, x[7], x[7:1]};
          end
        endcase
      end
    end
    if (!w) x[15:8] = 8'h00;
    return {cy, x};
  endfunction

  // {bytes, clocks} before the RAM-fetch stretch
  function automatic logic [8:0] cost(input casbd_req_t r);
    logic [2:0] by;
    logic [5:0] ck;
    by = `CASBD_BY_TWO;
    ck = `CASBD_CLK_ONE;
    unique case (r.op)
      OP_WORD_ADD, OP_WORD_SUBTRACT, OP_WORD_COMPARE: begin
        by = (r.src == SRC_REG) ? `CASBD_BY_ONE : `CASBD_BY_THREE;
        if (r.src == SRC_MEM && r.flash) ck = `CASBD_CLK_FLASH;
      end
      OP_BYTE_UNSIGNED_MULTIPLY: by = `CASBD_BY_ONE;
      OP_WORD_UNSIGNED_MULTIPLY, OP_WORD_SIGNED_MULTIPLY: begin
        by = `CASBD_BY_THREE;
        ck = `CASBD_CLK_MUL16;
      end
      OP_UNSIGNED_PRODUCT_ACCUMULATE, OP_SIGNED_PRODUCT_ACCUMULATE: begin
        by = `CASBD_BY_THREE;
        ck = `CASBD_CLK_MAC;
      end
      OP_WORD_UNSIGNED_DIVIDE: begin
        by = `CASBD_BY_THREE;
        ck = `CASBD_CLK_DIVH;
      end
      OP_LONG_UNSIGNED_DIVIDE: begin
        by = `CASBD_BY_THREE;
        ck = `CASBD_CLK_DIVW;
      end
      OP_BYTE_ADD_ONE, OP_BYTE_SUBTRACT_ONE, OP_WORD_ADD_ONE, OP_WORD_SUBTRACT_ONE: begin
        by = (r.src == SRC_MEM) ? `CASBD_BY_THREE : `CASBD_BY_ONE;
        if (r.src == SRC_MEM) ck = `CASBD_CLK_RMW;
      end
      OP_BIT_TO_CARRY, OP_SINGLE_BIT_AND, OP_SINGLE_BIT_OR: begin
        by = (r.src == SRC_PSW || r.src == SRC_SFR) ? `CASBD_BY_THREE : `CASBD_BY_TWO;
        if (r.src == SRC_MEM && r.flash) ck = `CASBD_CLK_FLASH;
      end
      OP_CARRY_TO_BIT: begin
        by = (r.src == SRC_PSW || r.src == SRC_SFR) ? `CASBD_BY_THREE : `CASBD_BY_TWO;
        if (r.src == SRC_PSW) ck = `CASBD_CLK_PSWBIT;
        else if (r.src != SRC_ACC) ck = `CASBD_CLK_RMW;
      end
      default: by = `CASBD_BY_TWO;
    endcase
    if (r.es) begin
      by = by + 3'd1;
      ck = ck + `CASBD_CLK_ES;
    end
    return {by, ck};
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    logic [31:0] m;
    m = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) m[8*i +: 8] = n[8*i +: 8];
    end
    return m;
  endfunction

  logic take;
  assign op_ready = (q.st == ST_IDLE);
  assign take = op_valid && op_ready;
  assign s_axi_awready = !q.aw_got && !q.bvalid;
  assign s_axi_wready = !q.w_got && !q.bvalid;
  assign s_axi_arready = !q.rvalid;
  assign op_done = q.done;
  assign op_rsp = q.rsp;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rresp = q.rresp;
  assign s_axi_rdata = q.rdata;

  always_comb begin
    logic [15:0] opd, ax, w16;
    logic [7:0] b8;
    logic [17:0] as;
    logic [16:0] sh;
    logic [31:0] p32, dvd, dvs;
    logic [32:0] acc;
    logic [8:0] cs;
    logic [5:0] ck;
    logic bsrc, cy;
    logic [1:0] pi;
    d = q;
    d.done = 1'b0;
    ax = q.rp[0];
    cy = q.program_status_word[`CASBD_PSW_CY];
    pi = op_req.rsel[1:0];
    opd = (op_req.src == SRC_IMM) ? op_req.imm :
          (op_req.src == SRC_REG) ? q.rp[pi] : op_req.mem;
    b8 = (op_req.src == SRC_MEM) ? op_req.mem[7:0] :
         q.rp[op_req.rsel[2:1]][8*op_req.rsel[0] +: 8];
    w16 = (op_req.src == SRC_MEM) ? op_req.mem : q.rp[pi];
    bsrc = (op_req.src == SRC_ACC) ? ax[8 + op_req.bitn] :
           (op_req.src == SRC_PSW) ? q.program_status_word[op_req.bitn] : op_req.mem[op_req.bitn];
    as = '0;
    sh = '0;
    p32 = '0;
    acc = '0;
    dvd = '0;
    dvs = '0;
    cs = cost(op_req);
    // instruction time doubles plus three when fetched from internal RAM
    ck = q.ctrl[`CASBD_CTRL_RAMF] ? 6'((cs[5:0] << 1) + `CASBD_CLK_RAMF) : cs[5:0];

    // register writes from software land first; an operation taken this cycle overrides
    if (q.aw_got && q.w_got && !q.bvalid) begin
      d.aw_got = 1'b0;
      d.w_got = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = `CASBD_RESP_OK;
      unique case (q.awaddr)
        `CASBD_A_AX: d.rp[0] = 16'(merge({16'h0000, q.rp[0]}, q.wdata, q.wstrb));
        `CASBD_A_BC: d.rp[1] = 16'(merge({16'h0000, q.rp[1]}, q.wdata, q.wstrb));
        `CASBD_A_DE: d.rp[2] = 16'(merge({16'h0000, q.rp[2]}, q.wdata, q.wstrb));
        `CASBD_A_HL: d.rp[3] = 16'(merge({16'h0000, q.rp[3]}, q.wdata, q.wstrb));
        `CASBD_A_MACL: d.mac[15:0] = 16'(merge({16'h0000, q.mac[15:0]}, q.wdata, q.wstrb));
        `CASBD_A_SIGNED_PRODUCT_ACCUMULATE: d.mac[31:16] = 16'(merge({16'h0000, q.mac[31:16]}, q.wdata, q.wstrb));
        `CASBD_A_PSW: d.program_status_word = 8'(merge({24'h0, q.program_status_word}, q.wdata, q.wstrb));
        `CASBD_A_CTRL: d.ctrl = 8'(merge({24'h0, q.ctrl}, q.wdata, q.wstrb));
        `CASBD_A_STAT: d.bresp = `CASBD_RESP_OK;
        default: d.bresp = `CASBD_RESP_ERR;
      endcase
    end
    if (s_axi_awvalid && s_axi_awready) begin
      d.aw_got = 1'b1;
      d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      d.w_got = 1'b1;
      d.wdata = s_axi_wdata;
      d.wstrb = s_axi_wstrb;
    end
    if (q.bvalid && s_axi_bready) d.bvalid = 1'b0;
    if (q.rvalid && s_axi_rready) d.rvalid = 1'b0;
    if (s_axi_arvalid && s_axi_arready) begin
      d.rvalid = 1'b1;
      d.rresp = `CASBD_RESP_OK;
      d.rdata = '0;
      unique case (s_axi_araddr)
        `CASBD_A_AX: d.rdata[15:0] = q.rp[0];
        `CASBD_A_BC: d.rdata[15:0] = q.rp[1];
        `CASBD_A_DE: d.rdata[15:0] = q.rp[2];
        `CASBD_A_HL: d.rdata[15:0] = q.rp[3];
        `CASBD_A_MACL: d.rdata[15:0] = q.mac[15:0];
        `CASBD_A_SIGNED_PRODUCT_ACCUMULATE: d.rdata[15:0] = q.mac[31:16];
        `CASBD_A_PSW: d.rdata[7:0] = q.program_status_word;
        `CASBD_A_CTRL: d.rdata[7:0] = q.ctrl;
        `CASBD_A_STAT: d.rdata[0] = (q.st == ST_BUSY);
        default: d.rresp = `CASBD_RESP_ERR;
      endcase
    end

    unique case (q.st)
      ST_IDLE: begin
        if (take) begin
          d.st = (ck <= 6'd1) ? ST_IDLE : ST_BUSY;
          d.cnt = ck - 6'd1;
          d.done = (ck <= 6'd1);
          d.rsp = '{bytes: cs[8:6], clocks: ck, mem_we: 1'b0, mem_wdata: op_req.mem};
          unique case (op_req.op)
            OP_WORD_ADD, OP_WORD_SUBTRACT, OP_WORD_COMPARE: begin
              as = add_sub(ax, opd, op_req.op != OP_WORD_ADD);
              if (op_req.op != OP_WORD_COMPARE) d.rp[0] = as[15:0];
              d.program_status_word[`CASBD_PSW_Z] = (as[15:0] == 16'h0000);
              d.program_status_word[`CASBD_PSW_AC] = as[16];
              d.program_status_word[`CASBD_PSW_CY] = as[17];
            end
            OP_BYTE_UNSIGNED_MULTIPLY:
              d.rp[0] = {8'h00, ax[15:8]} * {8'h00, ax[7:0]};
            OP_WORD_UNSIGNED_MULTIPLY:
              {d.rp[1], d.rp[0]} = {16'h0000, ax} * {16'h0000, q.rp[1]};
            OP_WORD_SIGNED_MULTIPLY:
              {d.rp[1], d.rp[0]} = {{16{ax[15]}}, ax} * {{16{q.rp[1][15]}}, q.rp[1]};
            OP_WORD_UNSIGNED_DIVIDE: begin
              // a zero divisor gives an all-ones quotient and keeps the dividend as remainder
              d.rp[0] = (q.rp[2] == 16'h0000) ? 16'hffff : ax / q.rp[2];
              d.rp[2] = (q.rp[2] == 16'h0000) ? ax : ax % q.rp[2];
            end
            OP_LONG_UNSIGNED_DIVIDE: begin
              dvd = {q.rp[1], ax};
              dvs = {q.rp[3], q.rp[2]};
              {d.rp[1], d.rp[0]} = (dvs == 32'h0) ? 32'hffffffff : dvd / dvs;
              {d.rp[3], d.rp[2]} = (dvs == 32'h0) ? dvd : dvd % dvs;
            end
            OP_UNSIGNED_PRODUCT_ACCUMULATE, OP_SIGNED_PRODUCT_ACCUMULATE: begin
              p32 = (op_req.op == OP_SIGNED_PRODUCT_ACCUMULATE) ?
                    {{16{ax[15]}}, ax} * {{16{q.rp[1][15]}}, q.rp[1]} :
                    {16'h0000, ax} * {16'h0000, q.rp[1]};
              acc = {1'b0, q.mac} + {1'b0, p32};
              d.mac = acc[31:0];
              d.program_status_word[`CASBD_PSW_AC] = ({1'b0, q.mac[3:0]} + {1'b0, p32[3:0]}) > 5'h0f;
              d.program_status_word[`CASBD_PSW_CY] = acc[32];
            end
            OP_BYTE_ADD_ONE, OP_BYTE_SUBTRACT_ONE: begin
              as = add_sub({8'h00, b8}, 16'h0001, op_req.op == OP_BYTE_SUBTRACT_ONE);
              d.program_status_word[`CASBD_PSW_Z] = (as[7:0] == 8'h00);
              d.program_status_word[`CASBD_PSW_AC] = as[16];
              if (op_req.src == SRC_MEM) begin
                d.rsp.mem_we = 1'b1;
                d.rsp.mem_wdata = {8'h00, as[7:0]};
              end else begin
                d.rp[op_req.rsel[2:1]][8*op_req.rsel[0] +: 8] = as[7:0];
              end
            end
            OP_WORD_ADD_ONE, OP_WORD_SUBTRACT_ONE: begin
              as = add_sub(w16, 16'h0001, op_req.op == OP_WORD_SUBTRACT_ONE);
              if (op_req.src == SRC_MEM) begin
                d.rsp.mem_we = 1'b1;
                d.rsp.mem_wdata = as[15:0];
              end else begin
                d.rp[pi] = as[15:0];
              end
            end
            OP_BYTE_LOGICAL_RIGHT, OP_BYTE_LEFT_MOVE, OP_BYTE_ARITH_RIGHT: begin
              sh = shift_n({8'h00, b8}, cy, op_req.cnt, 1'b0,
                           (op_req.op == OP_BYTE_LEFT_MOVE) ? SHK_LEFT :
                           (op_req.op == OP_BYTE_LOGICAL_RIGHT) ? SHK_LOG : SHK_ARITH);
              d.rp[op_req.rsel[2:1]][8*op_req.rsel[0] +: 8] = sh[7:0];
              d.program_status_word[`CASBD_PSW_CY] = sh[16];
            end
            OP_WORD_LOGICAL_RIGHT, OP_WORD_LEFT_MOVE, OP_WORD_ARITH_RIGHT: begin
              sh = shift_n(q.rp[pi], cy, op_req.cnt, 1'b1,
                           (op_req.op == OP_WORD_LEFT_MOVE) ? SHK_LEFT :
                           (op_req.op == OP_WORD_LOGICAL_RIGHT) ? SHK_LOG : SHK_ARITH);
              d.rp[pi] = sh[15:0];
              d.program_status_word[`CASBD_PSW_CY] = sh[16];
            end
            OP_BYTE_ROTATE_RIGHT: begin
              d.rp[0][15:8] = {ax[8], ax[15:9]};
              d.program_status_word[`CASBD_PSW_CY] = ax[8];
            end
            OP_BYTE_ROTATE_LEFT: begin
              d.rp[0][15:8] = {ax[14:8], ax[15]};
              d.program_status_word[`CASBD_PSW_CY] = ax[15];
            end
            OP_ROTATE_RIGHT_THROUGH_CARRY: begin
              d.rp[0][15:8] = {cy, ax[15:9]};
              d.program_status_word[`CASBD_PSW_CY] = ax[8];
            end
            OP_ROTATE_LEFT_THROUGH_CARRY: begin
              d.rp[0][15:8] = {ax[14:8], cy};
              d.program_status_word[`CASBD_PSW_CY] = ax[15];
            end
            OP_WORD_ROTATE_LEFT_THROUGH_CARRY: begin
              d.rp[pi] = {q.rp[pi][14:0], cy};
              d.program_status_word[`CASBD_PSW_CY] = q.rp[pi][15];
            end
            OP_BIT_TO_CARRY: d.program_status_word[`CASBD_PSW_CY] = bsrc;
            OP_SINGLE_BIT_AND: d.program_status_word[`CASBD_PSW_CY] = cy & bsrc;
            OP_SINGLE_BIT_OR: d.program_status_word[`CASBD_PSW_CY] = cy | bsrc;
            OP_CARRY_TO_BIT: begin
              // writing into the status word may land on zero or aux carry as well
              if (op_req.src == SRC_PSW) d.program_status_word[op_req.bitn] = cy;
              else if (op_req.src == SRC_ACC) d.rp[0][8 + op_req.bitn] = cy;
              else begin
                d.rsp.mem_we = 1'b1;
                d.rsp.mem_wdata[op_req.bitn] = cy;
              end
            end
            default: d.rsp.mem_we = 1'b0;
          endcase
        end
      end
      ST_BUSY: begin
        d.cnt = q.cnt - 6'd1;
        if (q.cnt <= 6'd1) begin
          d.st = ST_IDLE;
          d.done = 1'b1;
        end
      end
      default: d.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      q <= '0;
      q.st <= ST_IDLE;
      q.program_status_word <= `CASBD_PSW_RST;
    end else begin
      q <= d;
    end
  end

  logic [15:0] prod8;
  assign prod8 = {8'h00, q.rp[0][15:8]} * {8'h00, q.rp[0][7:0]};
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  cmp_keeps_acc_a: assert property (take && op_req.op == OP_WORD_COMPARE |=>
    q.rp[0] == $past(q.rp[0])) else $error("compare changed accumulator pair");
  add_imm_time_a: assert property (take && op_req.op == OP_WORD_ADD && op_req.src == SRC_IMM
    && !q.ctrl[`CASBD_CTRL_RAMF] |=> op_done && op_rsp.bytes == 3'd3) else $error("add timing");
  divh_time_a: assert property (take && op_req.op == OP_WORD_UNSIGNED_DIVIDE
    && !q.ctrl[`CASBD_CTRL_RAMF] |=> !op_done [*8] ##1 op_done) else $error("divide not 9");
  divw_time_a: assert property (take && op_req.op == OP_LONG_UNSIGNED_DIVIDE
    && !q.ctrl[`CASBD_CTRL_RAMF] |-> ##17 op_done) else $error("long divide not 17");
  ramf_time_a: assert property (take && op_req.op == OP_WORD_UNSIGNED_DIVIDE
    && q.ctrl[`CASBD_CTRL_RAMF] |-> ##21 op_done) else $error("ram fetch stretch wrong");
  es_flash_a: assert property (take && op_req.op == OP_WORD_SUBTRACT && op_req.es
    && op_req.flash && op_req.src == SRC_MEM && !q.ctrl[`CASBD_CTRL_RAMF] |-> ##5 op_done
    && op_rsp.bytes == 3'd4) else $error("segment prefix timing");
  word_add_one_flags_a: assert property (take && op_req.op == OP_WORD_ADD_ONE |=>
    q.program_status_word == $past(q.program_status_word)) else $error("word increment touched flags");
  shift_zero_a: assert property (take && op_req.cnt == 4'd0 && op_req.op == OP_WORD_LEFT_MOVE
    |=> q.rp == $past(q.rp) && $stable(q.program_status_word)) else $error("zero count changed state");
  mul8_prod_a: assert property (take && op_req.op == OP_BYTE_UNSIGNED_MULTIPLY |=>
    q.rp[0] == $past(prod8) && $stable(q.program_status_word)) else $error("byte product wrong");
  inc_carry_a: assert property (take && op_req.op == OP_BYTE_ADD_ONE |=>
    q.program_status_word[`CASBD_PSW_CY] == $past(q.program_status_word[`CASBD_PSW_CY])) else $error("byte increment hit carry");

  div_seen_c: cover property (take && op_req.op == OP_LONG_UNSIGNED_DIVIDE ##17 op_done);
  mac_carry_c: cover property (take && op_req.op == OP_SIGNED_PRODUCT_ACCUMULATE
    ##1 q.program_status_word[`CASBD_PSW_CY]);
  axi_write_c: cover property (s_axi_bvalid && s_axi_bready);
endmodule

// ==== dv/casbd_seq_model.sv ====
// sequencer model: performs the memory write-back the datapath hands over
module casbd_seq_model (
  input wire logic sys_clk, // cpu clock
  input wire logic op_done, // operation finished
  input wire casbd_pkg::casbd_rsp_t op_rsp, // write-back request
  output logic [15:0] mem_word // last word written back
);
  import casbd_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge sys_clk) begin
    if (op_done && op_rsp.mem_we) begin
      mem_word <= op_rsp.mem_wdata;
    end
  end
endmodule

// ==== dv/casbd_datapath_bench.sv ====
// self-checking bench of the execution datapath
`define CHK(n, e, g) begin tests_run++; if ((e) !== (g)) begin bad_count++; \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module casbd_datapath_bench;
  import casbd_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 0, rst_n = 0, op_valid = 0, op_ready, op_done;
  casbd_req_t op_req = '0;
  casbd_rsp_t op_rsp;
  logic [5:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [15:0] mem_word;
  int bad_count = 0, tests_run = 0;
  casbd_datapath uut (.sys_clk, .rst_n, .op_valid, .op_ready, .op_req, .op_done, .op_rsp,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);
  casbd_seq_model seq (.sys_clk, .op_done, .op_rsp, .mem_word);
  always #5 sys_clk = ~sys_clk;
  // handshakes are read just after the rising edge, before the design's update lands
  task automatic wr(input logic [5:0] a, input logic [15:0] v);
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0, v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
    do @(posedge sys_clk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge sys_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge sys_clk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic op(input casbd_op_t o, input casbd_src_t s, input logic [1:0] ef,
    input logic [15:0] v, input logic [3:0] n, input logic [5:0] c, input logic [2:0] b);
    logic [5:0] k;
    @(posedge sys_clk);
    op_valid <= 1'b1;
    op_req <= '{o, s, ef[1], ef[0], 3'd1, n, 3'd0, v, v};
    @(posedge sys_clk);
    op_valid <= 1'b0;
    k = 6'd1;
    #1;
    while (op_done !== 1'b1 && k < 6'd40) @(posedge sys_clk) #1 k++;
    `CHK("clocks", c, k)
    `CHK("bytes", b, op_rsp.bytes)
  endtask
  task automatic t_add;
    wr(6'h00, 16'h8ff8);
    op(OP_WORD_ADD, SRC_IMM, 2'b00, 16'h7008, 4'd0, 6'd1, 3'd3);
    rd(6'h00);
    `CHK("sum", 32'h0, d)
    rd(6'h18);
    `CHK("add flags", 32'h51, d & 32'h51)
  endtask
  task automatic t_cmp;
    wr(6'h00, 16'h0005);
    op(OP_WORD_COMPARE, SRC_IMM, 2'b00, 16'h0006, 4'd0, 6'd1, 3'd3);
    rd(6'h00);
    `CHK("kept", 32'h5, d)
    rd(6'h18);
    `CHK("cmp flags", 32'h11, d & 32'h51)
  endtask
  task automatic t_mem;
    op(OP_WORD_SUBTRACT, SRC_MEM, 2'b01, 16'h0, 4'd0, 6'd4, 3'd3);
    op(OP_WORD_SUBTRACT, SRC_MEM, 2'b11, 16'h0, 4'd0, 6'd5, 3'd4);
    op(OP_WORD_ADD_ONE, SRC_MEM, 2'b00, 16'hffff, 4'd0, 6'd2, 3'd3);
    @(posedge sys_clk) #1;
    `CHK("write back", 16'h0, mem_word)
  endtask
  task automatic t_div;
    wr(6'h00, 16'd100);
    wr(6'h08, 16'd7);
    op(OP_WORD_UNSIGNED_DIVIDE, SRC_REG, 2'b00, 16'h0, 4'd0, 6'd9, 3'd3);
    rd(6'h00);
    `CHK("quotient", 32'd14, d)
    rd(6'h08);
    `CHK("remainder", 32'd2, d)
    op(OP_LONG_UNSIGNED_DIVIDE, SRC_REG, 2'b00, 16'h0, 4'd0, 6'd17, 3'd3);
    rd(6'h00);
    `CHK("long quotient", 32'd7, d)
  endtask
  task automatic t_more;
    wr(6'h00, 16'h0c0b);
    op(OP_BYTE_UNSIGNED_MULTIPLY, SRC_REG, 2'b00, 16'h0, 4'd0, 6'd1, 3'd1);
    rd(6'h00);
    `CHK("byte product", 32'h84, d)
    op(OP_BYTE_ADD_ONE, SRC_REG, 2'b00, 16'h0, 4'd0, 6'd1, 3'd1);
    rd(6'h00);
    `CHK("byte plus one", 32'h184, d)
    op(OP_WORD_LEFT_MOVE, SRC_REG, 2'b00, 16'h0, 4'd0, 6'd1, 3'd2);
    wr(6'h00, 16'hfffe);
    wr(6'h04, 16'h0003);
    op(OP_WORD_SIGNED_MULTIPLY, SRC_REG, 2'b00, 16'h0, 4'd0, 6'd2, 3'd3);
    rd(6'h04);
    `CHK("signed high", 32'hffff, d)
    op(OP_UNSIGNED_PRODUCT_ACCUMULATE, SRC_REG, 2'b00, 16'h0, 4'd0, 6'd3, 3'd3);
    rd(6'h14);
    `CHK("mac high", 32'hfff9, d)
    wr(6'h1c, 16'h0001);
    op(OP_WORD_UNSIGNED_DIVIDE, SRC_REG, 2'b00, 16'h0, 4'd0, 6'd21, 3'd3);
  endtask
  task automatic t_shift;
    wr(6'h00, 16'h8100);
    op(OP_BYTE_LOGICAL_RIGHT, SRC_REG, 2'b00, 16'h0, 4'd1, 6'd1, 3'd2);
    rd(6'h00);
    `CHK("shifted", 32'h4000, d)
    rd(6'h18);
    `CHK("carry out", 32'h1, d & 32'h1)
    rd(6'h24);
    `CHK("unmapped", 2'b10, r)
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    #100us;
    bad_count++;
    results();
  end
  initial begin
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_add();
    t_cmp();
    t_mem();
    t_div();
    t_shift();
    t_more();
    results();
  end
endmodule
